// >>> design/interval_timer_channel.sv
// channel 0 interval timer with register port, interrupt and event out
//----------------------------------------------------------------------
// Summary of operation
// RL1 - writing 1 to channel 0 stop bit halts counting; 0 does nothing
// RL2 - channel 1/3 stop bit in 8-bit mode stops only the lower timer
// RL3 - mask bit 0 lets the request through, 1 blocks it
// RL4 - request flag reads 1 while pending; software writes 0 to clear
// RL5 - two priority bits give levels 0 (highest) to 3 (lowest)
// RL6 - clock select 00/01/10/11 picks prescaled clock 0/2/1/3
// RL7 - software never picks prescaled clocks 2 or 3 for channel 0
// RL8 - count select 0 counts operation clock, 1 counts input pin edges
// RL9 - start source: software, input edge, both edges, or master irq
// RL10 - mode field picks interval, capture, event, one-count modes
// RL11 - interval/capture: bit 0 set gives irq and toggle at start
// RL12 - one-count: bit 0 set accepts restart during count, with irq
// RL13 - software keeps bit 0 clear in event and capture-one-count
// RL14 - data value plus one count clocks make one period
// RL15 - output value bit sets the timer output level
// RL16 - enable 0: software owns output bit; enable 1: timer owns it
// RL17 - writing start bit sets enabled status and enables counting
// RL18 - interval down counter reloads at zero, flags irq and event
//----------------------------------------------------------------------
`timescale 1ns/1ps
module interval_timer_channel #(
  parameter int CNT_W = 16 // counter width
) (
  input wire logic core_clk_i, // system clock
  input wire logic rst_n_i, // async reset, active low
  input wire logic [3:0] addr_i, // register index
  input wire logic [15:0] wdata_i, // write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  input wire logic timer_input_pin_i, // external timer input pin
  input wire logic master_irq_i, // master channel interrupt, same clock
  output logic [15:0] rdata_o, // read data, one cycle later
  output logic chan0_output_value_o, // timer output pin level
  output logic count_end_o, // count-end event pulse to event link
  output logic irq_req_o, // unmasked interrupt request
  output logic [1:0] irq_level_o, // priority level of request
  output logic irq_o, // sticky status interrupt
  output logic chan1_low_stop_o, // lower 8-bit stop pulse, channel 1
  output logic chan3_low_stop_o // lower 8-bit stop pulse, channel 3
);
  import itimer_pkg::*;

  //--------------------------------------------------------------------
  // registers
  //--------------------------------------------------------------------
  logic [7:0] mask_q, req_q, prio_hi_q, prio_lo_q;
  logic [15:0] mode_q, data_q, out_q, outen_q, presc_q;
  logic [1:0] istat_q, imask_q;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [15:0] rdata_q;
  logic [PRESC_W-1:0] div_q;
  logic pin_s1_q, pin_s2_q, pin_s3_q;
  logic enabled_q;
  logic count_end_q, irq_req_q, irq_q, st1_q, st3_q;
  logic [1:0] irq_level_q;
  chan_state_e state_q, state_d;

  reg_req_s req;
  mode_fields_s f;
  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
  assign f = unpack_mode(mode_q);

  //--------------------------------------------------------------------
  // write decode
  //--------------------------------------------------------------------
  wire wr_start = req.wr && req.addr == ADDR_START;
  wire wr_stop = req.wr && req.addr == ADDR_STOP;
  wire start_trig = wr_start && req.wdata[CH0_BIT]; // RL17
  wire stop_trig = wr_stop && req.wdata[CH0_BIT]; // RL1
  wire rd_istat = req.rd && req.addr == ADDR_ISTAT;

  //--------------------------------------------------------------------
  // prescaled clocks: enables from a free divider, 4 taps per presc
  //--------------------------------------------------------------------
  wire [PRESC_W-1:0] div_next = div_q + 1'b1;
  function automatic logic tap(input logic [PRESC_W-1:0] d,
                               input logic [PRESC_W-1:0] nd,
                               input logic [3:0] sel);
    // pulse when bit sel-1 of divider wraps, whole divider for sel above 4; sel 0 means every cycle
    if (sel == 4'h0)
      return 1'b1;
    return d[sel[1:0]-2'd1] && !nd[sel[1:0]-2'd1] && sel <= 4'h4 ?
           1'b1 : (sel > 4'h4 && nd == '0);
  endfunction
  wire ck0 = tap(div_q, div_next, presc_q[3:0]);
  wire ck1 = tap(div_q, div_next, presc_q[7:4]);
  wire ck2 = tap(div_q, div_next, presc_q[11:8]);
  wire ck3 = tap(div_q, div_next, presc_q[15:12]);

  // operation clock select; codes 01/11 reserved for channels 1 and 3
  wire op_tick = (f.cks == CKS_CK0) ? ck0 : // RL6
                 (f.cks == CKS_CK2) ? ck2 : // RL7
                 (f.cks == CKS_CK1) ? ck1 : ck3; // RL6

  //--------------------------------------------------------------------
  // input pin sync and edges, sampled on operation clock
  //--------------------------------------------------------------------
  wire pin_rise = pin_s2_q && !pin_s3_q;
  wire pin_fall = !pin_s2_q && pin_s3_q;
  wire pin_edge_valid = pin_rise; // valid edge taken as rising
  wire count_tick = f.ccs ? pin_edge_valid : op_tick; // RL8

  // start trigger source select
  wire hw_trig = (f.sts == STS_EDGE) ? pin_edge_valid : // RL9
                 (f.sts == STS_BOTH) ? (pin_rise || pin_fall) : // RL9
                 (f.sts == STS_MASTER) ? master_irq_i : 1'b0; // RL9

  //--------------------------------------------------------------------
  // channel sequencer
  //--------------------------------------------------------------------
  wire md_int_cap = f.md == MD_INTERVAL || f.md == MD_CAPTURE;
  wire md_one = f.md == MD_ONECOUNT || f.md == MD_CAP_ONE;
  wire md_up = f.md == MD_CAPTURE || f.md == MD_CAP_ONE; // RL10
  wire soft_only = f.sts == STS_SOFT;
  wire go_now = state_q == ST_WAIT && (soft_only || hw_trig);
  wire restart = state_q == ST_RUN && md_one && hw_trig &&
                 f.md == MD_ONECOUNT && f.md0; // RL12
  wire at_zero = cnt_q == '0;
  wire run_tick = state_q == ST_RUN && count_tick;
  wire down_end = run_tick && !md_up && at_zero; // RL18
  wire up_wrap = run_tick && md_up && (&cnt_q);
  wire start_evt = go_now && md_int_cap && f.md0; // RL11
  wire cap_evt = state_q == ST_RUN && md_up && hw_trig;
  wire tick_evt = down_end || up_wrap || start_evt || restart || cap_evt;

  // next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: if (start_trig) state_d = ST_WAIT; // RL17
      ST_WAIT: if (go_now) state_d = ST_RUN;
      ST_RUN: begin
        if (down_end && md_one)
          state_d = ST_WAIT; // one-count waits for next trigger
      end
      default: state_d = ST_IDLE;
    endcase
    if (stop_trig) // RL1
      state_d = ST_IDLE;
  end

  // counter next value
  always_comb begin
    cnt_d = cnt_q;
    if (go_now || restart)
      cnt_d = md_up ? '0 : data_q[CNT_W-1:0]; // RL18
    else if (cap_evt)
      cnt_d = '0;
    else if (down_end)
      cnt_d = data_q[CNT_W-1:0]; // RL14
    else if (run_tick)
      cnt_d = md_up ? cnt_q + 1'b1 : cnt_q - 1'b1; // RL10
  end

  //--------------------------------------------------------------------
  // timer output control
  //--------------------------------------------------------------------
  wire out_toggle = outen_q[CH0_BIT] && tick_evt && !cap_evt; // RL16
  wire out_sw_wr = req.wr && req.addr == ADDR_OUT;
  wire [15:0] out_d = {out_sw_wr ? {req.wdata[15:1] & 15'h0007} :
                       out_q[15:1],
                       out_toggle ? !out_q[CH0_BIT] :
                       (out_sw_wr && !outen_q[CH0_BIT]) ? // RL16
                       req.wdata[CH0_BIT] : out_q[CH0_BIT]};

  //--------------------------------------------------------------------
  // interrupt request flag: set wins over software clear
  //--------------------------------------------------------------------
  wire req_wr = req.wr && req.addr == ADDR_REQ;
  wire [7:0] req_d = (req_wr ? req.wdata[7:0] : req_q) |
                     ({7'h00, tick_evt} << IRQ_BIT); // RL4
  wire [1:0] ev_vec = {stop_trig, tick_evt};
  wire [1:0] istat_d = (rd_istat ? 2'b00 : istat_q) | ev_vec;

  //--------------------------------------------------------------------
  // read mux
  //--------------------------------------------------------------------
  wire [15:0] rd_mux =
    (req.addr == ADDR_MASK) ? {8'h00, mask_q} :
    (req.addr == ADDR_REQ) ? {8'h00, req_q} : // RL4
    (req.addr == ADDR_PRIO_HI) ? {8'h00, prio_hi_q} :
    (req.addr == ADDR_PRIO_LO) ? {8'h00, prio_lo_q} :
    (req.addr == ADDR_MODE) ? mode_q :
    (req.addr == ADDR_DATA) ? data_q :
    (req.addr == ADDR_OUT) ? out_q : // RL15
    (req.addr == ADDR_OUTEN) ? outen_q :
    (req.addr == ADDR_START) ? {15'h0000, enabled_q} : // RL17
    (req.addr == ADDR_PRESC) ? presc_q :
    (req.addr == ADDR_ISTAT) ? {14'h0000, istat_q} :
    (req.addr == ADDR_IMASK) ? {14'h0000, imask_q} : 16'h0000;

  //--------------------------------------------------------------------
  // software registers
  //--------------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mask_q <= MASK_RST;
      prio_hi_q <= MASK_RST;
      prio_lo_q <= MASK_RST;
      mode_q <= MODE_RST;
      data_q <= DATA_RST;
      outen_q <= WORD_RST;
      presc_q <= WORD_RST;
      imask_q <= 2'h0;
    end else if (req.wr) begin
      if (req.addr == ADDR_MASK) mask_q <= req.wdata[7:0]; // RL3
      if (req.addr == ADDR_PRIO_HI) prio_hi_q <= req.wdata[7:0]; // RL5
      if (req.addr == ADDR_PRIO_LO) prio_lo_q <= req.wdata[7:0]; // RL5
      if (req.addr == ADDR_MODE) mode_q <= req.wdata;
      if (req.addr == ADDR_DATA) data_q <= req.wdata; // RL14
      if (req.addr == ADDR_OUTEN) outen_q <= req.wdata & 16'h000f;
      if (req.addr == ADDR_PRESC) presc_q <= req.wdata;
      if (req.addr == ADDR_IMASK) imask_q <= req.wdata[1:0];
    end
  end

  // timer state, flags and outputs
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
      enabled_q <= 1'b0;
      out_q <= WORD_RST;
      req_q <= BYTE_RST;
      istat_q <= 2'h0;
      div_q <= '0;
      {pin_s1_q, pin_s2_q, pin_s3_q} <= 3'b000;
      rdata_q <= WORD_RST;
      {count_end_q, irq_req_q, irq_q, st1_q, st3_q} <= 5'h00;
      irq_level_q <= 2'h3;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      enabled_q <= state_d != ST_IDLE; // RL17
      out_q <= out_d; // RL15
      req_q <= req_d;
      istat_q <= istat_d;
      div_q <= div_next;
      pin_s1_q <= timer_input_pin_i;
      pin_s2_q <= pin_s1_q;
      if (op_tick) pin_s3_q <= pin_s2_q;
      rdata_q <= req.rd ? rd_mux : 16'h0000;
      count_end_q <= down_end; // RL18
      irq_req_q <= req_d[IRQ_BIT] && !mask_q[IRQ_BIT]; // RL3
      irq_level_q <= {prio_hi_q[IRQ_BIT], prio_lo_q[IRQ_BIT]}; // RL5
      irq_q <= |(istat_d & imask_q);
      st1_q <= wr_stop && req.wdata[CH1_BIT]; // RL2
      st3_q <= wr_stop && req.wdata[CH3_BIT]; // RL2
    end
  end

  assign rdata_o = rdata_q;
  assign chan0_output_value_o = out_q[CH0_BIT];
  assign count_end_o = count_end_q;
  assign irq_req_o = irq_req_q;
  assign irq_level_o = irq_level_q;
  assign irq_o = irq_q;
  assign chan1_low_stop_o = st1_q;
  assign chan3_low_stop_o = st3_q;
endmodule // interval_timer_channel

// >>> inc/itimer_pkg.sv
// package of constants and types for the interval timer channel
package itimer_pkg;
  // register indices on the plain register port
  localparam logic [3:0] ADDR_MASK = 4'h0; // intr_mask_low_1
  localparam logic [3:0] ADDR_REQ = 4'h1; // intr_request_low_1
  localparam logic [3:0] ADDR_PRIO_HI = 4'h2; // intr_priority_hi_bit_low_1
  localparam logic [3:0] ADDR_PRIO_LO = 4'h3; // intr_priority_lo_bit_low_1
  localparam logic [3:0] ADDR_MODE = 4'h4; // channel0_mode
  localparam logic [3:0] ADDR_DATA = 4'h5; // channel0_interval_data
  localparam logic [3:0] ADDR_OUT = 4'h6; // timer_output_levels
  localparam logic [3:0] ADDR_OUTEN = 4'h7; // timer_output_enables
  localparam logic [3:0] ADDR_START = 4'h8; // start trigger / enabled status
  localparam logic [3:0] ADDR_STOP = 4'h9; // stop trigger
  localparam logic [3:0] ADDR_PRESC = 4'ha; // prescaler selects
  localparam logic [3:0] ADDR_ISTAT = 4'hb; // sticky event status
  localparam logic [3:0] ADDR_IMASK = 4'hc; // event mask

  // field positions
  localparam int IRQ_BIT = 4; // chan0 bit in the 8-bit irq registers
  localparam int CKS_LSB = 14;
  localparam int CCS_BIT = 12;
  localparam int STS_LSB = 8;
  localparam int MD_LSB = 1;
  localparam int MD0_BIT = 0;
  localparam int CH0_BIT = 0;
  localparam int CH1_BIT = 1;
  localparam int CH3_BIT = 3;
  localparam int PRESC_W = 4;

  // reset values
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [7:0] MASK_RST = 8'hff;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [15:0] WORD_RST = 16'h0000;

  // operation modes
  localparam logic [2:0] MD_INTERVAL = 3'h0;
  localparam logic [2:0] MD_CAPTURE = 3'h2;
  localparam logic [2:0] MD_EVENT = 3'h3;
  localparam logic [2:0] MD_ONECOUNT = 3'h4;
  localparam logic [2:0] MD_CAP_ONE = 3'h6;

  // start trigger sources
  localparam logic [2:0] STS_SOFT = 3'h0;
  localparam logic [2:0] STS_EDGE = 3'h1;
  localparam logic [2:0] STS_BOTH = 3'h2;
  localparam logic [2:0] STS_MASTER = 3'h4;

  // operation clock select codes
  localparam logic [1:0] CKS_CK0 = 2'h0;
  localparam logic [1:0] CKS_CK2 = 2'h1;
  localparam logic [1:0] CKS_CK1 = 2'h2;
  localparam logic [1:0] CKS_CK3 = 2'h3;

  // timing: example interval from the setup
  localparam int SYS_CLK_MHZ = 100;
  localparam int EXAMPLE_PERIOD_US = 200;
  localparam int EXAMPLE_CYCLES = EXAMPLE_PERIOD_US * SYS_CLK_MHZ;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_RUN = 3'b100
  } chan_state_e;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  // mode register fields unpacked
  typedef struct packed {
    logic [1:0] cks;
    logic ccs;
    logic [2:0] sts;
    logic [2:0] md;
    logic md0;
  } mode_fields_s;

  function automatic mode_fields_s unpack_mode(input logic [15:0] m);
    mode_fields_s f;
    f.cks = m[CKS_LSB +: 2];
    f.ccs = m[CCS_BIT];
    f.sts = m[STS_LSB +: 3];
    f.md = m[MD_LSB +: 3];
    f.md0 = m[MD0_BIT];
    return f;
  endfunction
endpackage

// >>> verification/itimer_chk.sv
// port checker for the interval timer channel
`timescale 1ns/1ps
module itimer_chk
  import itimer_pkg::*;
(
  input wire logic core_clk_i, // clock
  input wire logic rst_n_i, // reset, active low
  input wire logic [3:0] addr_i, // register index
  input wire logic [15:0] wdata_i, // write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  input wire logic [15:0] rdata_o, // read data
  input wire logic chan0_output_value_o, // output level
  input wire logic count_end_o, // count-end pulse
  input wire logic irq_req_o, // request level
  input wire logic [1:0] irq_level_o, // request priority
  input wire logic irq_o, // status interrupt
  input wire logic chan1_low_stop_o, // stop pulse one
  input wire logic chan3_low_stop_o // stop pulse three
);
  logic mask_q;
  logic oe_q;
  logic [1:0] lvl_q;
  //----------------------------------------
  // shadows of written control bits
  //----------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mask_q <= 1'b1;
      oe_q <= 1'b0;
      lvl_q <= 2'h3;
    end else if (wr_i) begin
      if (addr_i == ADDR_MASK) mask_q <= wdata_i[IRQ_BIT];
      if (addr_i == ADDR_OUTEN) oe_q <= wdata_i[CH0_BIT];
      if (addr_i == ADDR_PRIO_HI) lvl_q[1] <= wdata_i[IRQ_BIT];
      if (addr_i == ADDR_PRIO_LO) lvl_q[0] <= wdata_i[IRQ_BIT];
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  //----------------------------------------
  // assertions
  //----------------------------------------
  a_rdata_quiet: assert property (
    !$past(rd_i) || $past(addr_i) > ADDR_IMASK |-> rdata_o == 16'h0000)
    else $error("read data not zero outside a read");
  a_level_follows: assert property (
    !$past(wr_i) && !$past(wr_i, 2) |-> irq_level_o == lvl_q)
    else $error("priority level differs from written bits");
  a_low_stop_one: assert property (
    chan1_low_stop_o == $past(wr_i && addr_i == ADDR_STOP && wdata_i[CH1_BIT]))
    else $error("channel one stop pulse wrong");
  a_low_stop_three: assert property (
    chan3_low_stop_o == $past(wr_i && addr_i == ADDR_STOP && wdata_i[CH3_BIT]))
    else $error("channel three stop pulse wrong");
  a_stop_quiet: assert property (
    wr_i && addr_i == ADDR_STOP && wdata_i[CH0_BIT] |-> ##2 !count_end_o [*2])
    else $error("count end after stop");
  a_req_masked: assert property (
    irq_req_o |-> !$past(mask_q))
    else $error("request passed while masked");
  a_req_after_end: assert property (
    count_end_o && !mask_q |-> ##[0:2] (irq_req_o || $past(wr_i)))
    else $error("no request after count end");
  a_out_held: assert property (
    $changed(chan0_output_value_o) && !$past(oe_q) && !$past(oe_q, 2)
      && !$past(oe_q, 3) |-> $past(wr_i && addr_i == ADDR_OUT))
    else $error("output moved without a write");
  c_count_end: cover property (count_end_o);
  c_req: cover property (irq_req_o);
  c_irq: cover property (irq_o);
  c_stop3: cover property (chan3_low_stop_o);
endmodule // itimer_chk

bind interval_timer_channel itimer_chk u_itimer_chk (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .chan0_output_value_o(chan0_output_value_o), .count_end_o(count_end_o),
  .irq_req_o(irq_req_o), .irq_level_o(irq_level_o), .irq_o(irq_o),
  .chan1_low_stop_o(chan1_low_stop_o), .chan3_low_stop_o(chan3_low_stop_o)
);

// >>> verification/irq_link_model.sv
// interrupt controller and event link beside the channel
`timescale 1ns/1ps
module irq_link_model (
  input wire logic core_clk_i, // clock
  input wire logic rst_n_i, // reset, active low
  input wire logic count_end_i, // count-end event
  input wire logic irq_req_i, // request level
  input wire logic [1:0] irq_level_i, // request priority
  output logic master_irq_o, // master interrupt pulse
  output logic [1:0] taken_level_o, // level at acceptance
  output logic [15:0] events_o // linked events
);
  // accept requests and count linked events
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      master_irq_o <= 1'b0;
      taken_level_o <= 2'h0;
      events_o <= 16'h0000;
    end else begin
      master_irq_o <= count_end_i; // master echo one cycle on
      if (count_end_i) events_o <= events_o + 16'h0001;
      if (irq_req_i) taken_level_o <= irq_level_i;
    end
  end
endmodule // irq_link_model

// >>> verification/tb_top.sv
// self-checking bench for the interval timer channel
`timescale 1ns/1ps
module tb_top;
  import itimer_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic pin = 1'b0;
  logic rd_seen = 1'b0;
  logic master_irq, out_v, count_end_o, irq_req_o, irq_o;
  logic [1:0] irq_level_o, taken;
  logic [15:0] rdata_o, events, d, e0;
  logic [15:0] cyc = 16'h0000;
  logic [31:0] seed = 32'h233c;
  logic [15:0] rd_q[$];
  logic [15:0] per_q[$];
  logic [2:0] mds[5] = '{MD_INTERVAL, MD_CAPTURE, MD_EVENT, MD_ONECOUNT,
    MD_CAP_ONE};
  logic [2:0] sts[4] = '{STS_SOFT, STS_EDGE, STS_BOTH, STS_MASTER};
  int fails = 0;
  int tests_run = 0;

  always #5 core_clk_i = ~core_clk_i;

  interval_timer_channel u_interval_timer_channel (.core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .timer_input_pin_i(pin), .master_irq_i(master_irq),
    .rdata_o(rdata_o), .chan0_output_value_o(out_v),
    .count_end_o(count_end_o), .irq_req_o(irq_req_o),
    .irq_level_o(irq_level_o), .irq_o(irq_o), .chan1_low_stop_o(),
    .chan3_low_stop_o());
  irq_link_model u_irq_link_model (.core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i), .count_end_i(count_end_o), .irq_req_i(irq_req_o),
    .irq_level_i(irq_level_o), .master_irq_o(master_irq),
    .taken_level_o(taken), .events_o(events));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    if (fails == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge core_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge core_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    rd_q.push_back(exp);
    @(posedge core_clk_i);
    rd_i <= 1'b0;
  endtask
  task automatic wait_end();
    int n;
    n = 0;
    while (count_end_o !== 1'b1 && n < 2000) begin
      @(posedge core_clk_i);
      n++;
    end
    if (n >= 2000) fails++;
    @(posedge core_clk_i);
  endtask
  // let registered outputs settle, then sample clear of the edge
  task automatic settle();
    repeat (2) @(posedge core_clk_i);
    #1;
  endtask

  // read data and period monitor, random pin
  always @(posedge core_clk_i) begin
    if (rd_seen) check(rdata_o, rd_q.pop_front());
    rd_seen <= rd_i;
    void'(xs());
    pin <= seed[3];
    if (count_end_o === 1'b1) begin
      if (per_q.size() > 0) check(cyc, per_q.pop_front());
      cyc <= 16'h0001;
    end else begin
      cyc <= cyc + 16'h0001;
    end
  end

  // watchdog
  initial begin
    #200000;
    fails++;
    wrap_up();
  end

  // main sequence
  initial begin
    repeat (3) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    reg_rd(ADDR_MASK, {8'h00, MASK_RST});
    reg_rd(ADDR_PRIO_HI, 16'h00ff);
    reg_rd(4'hf, 16'h0000);
    foreach (mds[i]) begin
      d = {i[0] ? CKS_CK1 : CKS_CK0, 3'h0, sts[i % 4], 4'h0, mds[i], 1'b0};
      reg_wr(ADDR_MODE, d);
      reg_rd(ADDR_MODE, d);
    end
    reg_wr(ADDR_MODE, 16'h0000);
    void'(xs());
    d = 16'h0008 + {11'h000, seed[4:0]};
    reg_wr(ADDR_DATA, d);
    reg_rd(ADDR_DATA, d);
    for (int lv = 0; lv < 4; lv++) begin
      reg_wr(ADDR_PRIO_HI, {11'h000, lv[1], 4'h0});
      reg_wr(ADDR_PRIO_LO, {11'h000, lv[0], 4'h0});
      settle();
      check({14'h0000, irq_level_o}, lv[15:0]);
    end
    reg_wr(ADDR_MASK, 16'h00ef);
    reg_wr(ADDR_IMASK, 16'h0001);
    reg_wr(ADDR_START, 16'h0001);
    reg_rd(ADDR_START, 16'h0001);
    wait_end();
    per_q.push_back(d + 16'h0001);
    per_q.push_back(d + 16'h0001);
    wait_end();
    wait_end();
    @(posedge core_clk_i);
    check({15'h0000, irq_req_o}, 16'h0001);
    reg_wr(ADDR_REQ, 16'h0000);
    settle();
    check({15'h0000, irq_req_o}, 16'h0000);
    check({14'h0000, taken}, 16'h0003);
    reg_wr(ADDR_MASK, 16'h00ff);
    wait_end();
    settle();
    check({15'h0000, irq_req_o}, 16'h0000);
    reg_wr(ADDR_STOP, 16'h000b);
    reg_rd(ADDR_START, 16'h0000);
    e0 = events;
    repeat (60) @(posedge core_clk_i);
    check(events, e0);
    check({15'h0000, irq_o}, 16'h0001);
    reg_rd(ADDR_ISTAT, 16'h0003);
    reg_rd(ADDR_ISTAT, 16'h0000);
    check({15'h0000, irq_o}, 16'h0000);
    reg_wr(ADDR_OUTEN, 16'h0000);
    reg_wr(ADDR_OUT, 16'h0001);
    settle();
    check({15'h0000, out_v}, 16'h0001);
    reg_wr(ADDR_OUTEN, 16'h0001);
    reg_wr(ADDR_OUT, 16'h0000);
    reg_rd(ADDR_OUT, 16'h0001);
    reg_wr(ADDR_REQ, 16'h0000);
    reg_wr(ADDR_MODE, 16'h0001);
    reg_wr(ADDR_START, 16'h0001);
    repeat (3) @(posedge core_clk_i);
    reg_rd(ADDR_REQ, 16'h0010);
    check({15'h0000, out_v}, 16'h0000);
    reg_wr(ADDR_STOP, 16'h0001);
    repeat (2) @(posedge core_clk_i);
    wrap_up();
  end
endmodule // tb_top
